// file: core/sdlc_core.sv
`timescale 1ns/1ps
module sdlc_core import sdlc_pkg::*; #(
	parameter int OSR       = OSR_DEF,
	parameter int MOD_DIV   = MOD_DIV_DEF,
	parameter int MUX_DIV   = MUX_DIV_DEF,
	parameter int SEG_N     = SEG_MAX,
	parameter bit FOUR_HALF = 1'b1
) (
	input  wire logic            clk_sys_in,
	input  wire logic            rst_n_in,
	input  wire logic            ce_in,
	input  wire logic            mod_bit_in,
	input  wire logic            ext_clk_in,
	input  wire logic            clock_source_select_in,
	input  wire logic            display_host_mode_in,
	input  wire sdlc_frame_type  host_frame_in,
	input  wire logic            range_fine_in,
	input  wire logic            result_read_in,
	output logic                 mod_clk_en_out,
	output sdlc_result_type      result_out,
	output logic                 eoc_n_out,
	output logic                 clock_source_active_out,
	output logic [15:0]          count_weight_uv_out,
	output logic                 backplane_drive_one_out,
	output logic                 backplane_drive_two_out,
	output logic                 backplane_drive_three_out,
	output logic [SEG_N-1:0]     segment_lines_out
);

	localparam int DEC_W = $clog2(OSR);
	localparam int ACC_W = SINC_ORDER * DEC_W + 1; // headroom for OSR^4 plus overrange
	localparam int DIV_W = $clog2(MOD_DIV);
	localparam int MUX_W = $clog2(MUX_DIV);

	// ---------------- clock source and modulator tick
	logic [PHASE_W-1:0] phase_ff;
	logic [PHASE_W-1:0] nxt_phase;
	logic               ext_prev_ff;
	logic               nxt_ext_prev;
	logic [DIV_W-1:0]   div_ff;
	logic [DIV_W-1:0]   nxt_div;
	logic               sel_ff;
	logic               nxt_sel;
	logic               mod_tick_ff;
	logic               nxt_mod_tick;
	logic [17:0]        phase_sum;
	logic               int_edge;
	logic               ext_edge;
	logic               src_edge;

	always_comb begin
		phase_sum = 18'({1'b0, phase_ff}) + PHASE_STEP;
		int_edge  = (phase_sum >= PHASE_MOD);
		nxt_phase = int_edge ? PHASE_W'(phase_sum - PHASE_MOD) : PHASE_W'(phase_sum);
		// external clock is sampled; its 5.05 MHz ceiling lies just above half the 10 MHz system rate
		nxt_ext_prev = ext_clk_in;
		ext_edge     = ext_clk_in & ~ext_prev_ff;
		src_edge     = sel_ff ? ext_edge : int_edge;
		nxt_div      = div_ff;
		nxt_mod_tick = 1'b0;
		nxt_sel      = sel_ff;
		if (src_edge) begin
			if (div_ff == DIV_W'(MOD_DIV - 1)) begin
				nxt_div      = '0;
				nxt_mod_tick = 1'b1; // all later rates derive from this tick
			end else begin
				nxt_div = DIV_W'(div_ff + 1'b1);
			end
		end
		// switch only between modulator periods, so none is cut short
		if (!src_edge && div_ff == '0 && clock_source_select_in != sel_ff) begin
			nxt_sel = clock_source_select_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_ff    <= '0;
			ext_prev_ff <= 1'b0;
			div_ff      <= '0;
			sel_ff      <= SEL_RST;
			mod_tick_ff <= 1'b0;
		end else if (ce_in) begin
			phase_ff    <= nxt_phase;
			ext_prev_ff <= nxt_ext_prev;
			div_ff      <= nxt_div;
			sel_ff      <= nxt_sel;
			mod_tick_ff <= nxt_mod_tick;
		end
	end

	// ---------------- sinc4 decimator
	logic [DEC_W-1:0] dec_cnt_ff;
	logic [DEC_W-1:0] nxt_dec_cnt;
	logic             dec_tick;
	logic [SINC_ORDER-2:0] dec_pipe_ff;
	logic [SINC_ORDER-2:0] nxt_dec_pipe;
	logic [SINC_ORDER-1:0] comb_en;
	logic [ACC_W-1:0] integ [0:SINC_ORDER];
	logic [ACC_W-1:0] comb  [0:SINC_ORDER];

	always_comb begin
		// N samples per word sets the first notch at the output rate
		dec_tick    = mod_tick_ff && (dec_cnt_ff == DEC_W'(OSR - 1));
		nxt_dec_cnt = dec_cnt_ff;
		if (mod_tick_ff) begin
			nxt_dec_cnt = dec_tick ? '0 : DEC_W'(dec_cnt_ff + 1'b1);
		end
		// combs ripple one clock apart, not one word apart, so settling stays at four words
		nxt_dec_pipe = {dec_pipe_ff[SINC_ORDER-3:0], dec_tick};
		comb_en      = {dec_pipe_ff, dec_tick};
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_cnt_ff  <= '0;
			dec_pipe_ff <= '0;
		end else if (ce_in) begin
			dec_cnt_ff  <= nxt_dec_cnt;
			dec_pipe_ff <= nxt_dec_pipe;
		end
	end

	// modulator bit is sampled on each tick it was clocked
	assign integ[0] = {{(ACC_W-1){1'b0}}, mod_bit_in};
	assign comb[0]  = integ[SINC_ORDER];

	// four integrators then four combs: notches at k*fout, cutoff 0.228 fout
	for (genvar g = 0; g < SINC_ORDER; g++) begin : g_stage
		sdlc_sinc_stage #(
			.W(ACC_W)
		) u_stage (
			.clk_sys_in  (clk_sys_in),
			.rst_n_in    (rst_n_in),
			.ce_in       (ce_in),
			.integ_en_in (mod_tick_ff),
			.comb_en_in  (comb_en[g]),
			.integ_in    (integ[g]),
			.integ_out   (integ[g+1]),
			.comb_in     (comb[g]),
			.comb_out    (comb[g+1])
		);
	end

	// ---------------- result, settling and end of conversion
	logic            word_stb_ff;
	logic            nxt_word_stb;
	logic [2:0]      word_cnt_ff;
	logic [2:0]      nxt_word_cnt;
	sdlc_result_type result_ff;
	sdlc_result_type nxt_result;
	logic            eoc_n_ff;
	logic            nxt_eoc_n;
	logic [OUT_W-1:0] new_word;
	logic [ACC_W+OUT_W-1:0] word_pad;
	logic [15:0]     cw_ff;
	logic [15:0]     nxt_cw;

	always_comb begin
		// zero fill below keeps a narrow accumulator legal and top-aligned
		word_pad     = {comb[SINC_ORDER], {OUT_W{1'b0}}};
		new_word     = word_pad[ACC_W+OUT_W-1 -: OUT_W];
		nxt_word_stb = dec_pipe_ff[SINC_ORDER-2];
		nxt_word_cnt = word_cnt_ff;
		nxt_result   = result_ff;
		nxt_eoc_n    = eoc_n_ff;
		if (word_stb_ff) begin
			if (word_cnt_ff != SETTLE_CNT) begin
				nxt_word_cnt = 3'(word_cnt_ff + 1'b1);
			end
			nxt_result.word    = new_word;
			nxt_result.settled = (nxt_word_cnt == SETTLE_CNT);
		end
		// a clock switch disturbs the filter history, so settling restarts
		if (sel_ff != nxt_sel) begin
			nxt_word_cnt       = '0;
			nxt_result.settled = 1'b0;
		end
		if (result_read_in) begin
			nxt_eoc_n = 1'b1;
		end
		if (word_stb_ff) begin
			nxt_eoc_n = 1'b0; // new word beats a read in the same cycle
		end
		nxt_cw = FOUR_HALF ? CW_UV_45 : CW_UV_35;
		if (range_fine_in) begin
			nxt_cw = 16'(nxt_cw / RANGE_FINE);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_stb_ff <= 1'b0;
			word_cnt_ff <= '0;
			result_ff   <= '0;
			eoc_n_ff    <= 1'b1;
			cw_ff       <= '0;
		end else if (ce_in) begin
			word_stb_ff <= nxt_word_stb;
			word_cnt_ff <= nxt_word_cnt;
			result_ff   <= nxt_result;
			eoc_n_ff    <= nxt_eoc_n;
			cw_ff       <= nxt_cw;
		end
	end

	// ---------------- triplexed display
	logic           refresh_cnt_ff;
	logic           nxt_refresh_cnt;
	logic           refresh_stb;
	sdlc_frame_type frame_ff;
	sdlc_frame_type nxt_frame;
	logic [MUX_W-1:0] mux_cnt_ff;
	logic [MUX_W-1:0] nxt_mux_cnt;
	logic [1:0]     bp_phase_ff;
	logic [1:0]     nxt_bp_phase;
	logic           pol_ff;
	logic           nxt_pol;
	logic [BP_N-1:0] bp_ff;
	logic [BP_N-1:0] nxt_bp;
	logic [SEG_N-1:0] seg_ff;
	logic [SEG_N-1:0] nxt_seg;

	always_comb begin
		// one refresh per two output words: 2.5 Hz at the nominal clock
		refresh_stb     = word_stb_ff && refresh_cnt_ff;
		nxt_refresh_cnt = word_stb_ff ? ~refresh_cnt_ff : refresh_cnt_ff;
		nxt_frame       = frame_ff;
		if (refresh_stb) begin
			// whole frame swapped at once, never a mix of old and new
			if (display_host_mode_in) begin
				nxt_frame = host_frame_in; // per-segment host control
			end else begin
				nxt_frame = sdlc_frame_type'(FRAME_W'(new_word));
			end
		end
		nxt_mux_cnt  = mux_cnt_ff;
		nxt_bp_phase = bp_phase_ff;
		nxt_pol      = pol_ff;
		if (mod_tick_ff) begin
			nxt_mux_cnt = MUX_W'(mux_cnt_ff + 1'b1);
			if (mux_cnt_ff == MUX_W'(MUX_DIV - 1)) begin
				nxt_mux_cnt = '0;
				if (bp_phase_ff == PHASE_LAST) begin
					nxt_bp_phase = '0;
					nxt_pol      = ~pol_ff; // alternate polarity keeps the panel free of dc
				end else begin
					nxt_bp_phase = 2'(bp_phase_ff + 1'b1);
				end
			end
		end
		// the active backplane sits opposite the idle ones; on segments oppose it
		for (int b = 0; b < BP_N; b++) begin
			nxt_bp[b] = nxt_pol ^ (nxt_bp_phase == 2'(b));
		end
		for (int s = 0; s < SEG_N; s++) begin
			nxt_seg[s] = nxt_pol ^ ~nxt_frame[nxt_bp_phase][s];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			refresh_cnt_ff <= 1'b0;
			frame_ff       <= '0;
			mux_cnt_ff     <= '0;
			bp_phase_ff    <= '0;
			pol_ff         <= 1'b0;
			bp_ff          <= 3'h1;
			seg_ff         <= '1;
		end else if (ce_in) begin
			refresh_cnt_ff <= nxt_refresh_cnt;
			frame_ff       <= nxt_frame;
			mux_cnt_ff     <= nxt_mux_cnt;
			bp_phase_ff    <= nxt_bp_phase;
			pol_ff         <= nxt_pol;
			bp_ff          <= nxt_bp;
			seg_ff         <= nxt_seg;
		end
	end

	assign mod_clk_en_out            = mod_tick_ff;
	assign result_out                = result_ff;
	assign eoc_n_out                 = eoc_n_ff;
	assign clock_source_active_out   = sel_ff;
	assign count_weight_uv_out       = cw_ff;
	assign backplane_drive_one_out   = bp_ff[0];
	assign backplane_drive_two_out   = bp_ff[1];
	assign backplane_drive_three_out = bp_ff[2];
	assign segment_lines_out         = seg_ff;

	// ---------------- checks
	a_eoc_new_word:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		word_stb_ff && ce_in |=> !eoc_n_out && result_out.word == $past(new_word))
	else $error("end of conversion not signalled with new word");

	a_eoc_read_clear:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		result_read_in && !word_stb_ff && ce_in |=> eoc_n_out)
	else $error("read did not release end of conversion");

	a_settle_four:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(result_out.settled) |-> $past(word_stb_ff) && word_cnt_ff == SETTLE_CNT)
	else $error("settled flag before four output words");

	a_switch_boundary:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!$stable(sel_ff) |-> $past(div_ff) == '0 && !$past(src_edge))
	else $error("clock source switched inside a modulator period");

	a_reset_internal:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> !clock_source_active_out)
	else $error("external clock active straight after reset");

	a_word_period:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		dec_tick |-> mod_tick_ff && dec_cnt_ff == DEC_W'(OSR - 1) ##4 word_stb_ff)
	else $error("output word not on the decimation boundary");

	a_frame_latch:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!$stable(frame_ff) |-> $past(refresh_stb) && $past(ce_in))
	else $error("display frame changed between refreshes");

	a_refresh_host:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		refresh_stb && display_host_mode_in && ce_in |=> frame_ff == $past(host_frame_in))
	else $error("host frame not taken at refresh");

	a_backplane_one:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$onehot(bp_ff ^ {BP_N{pol_ff}}))
	else $error("backplane drive not one active line");

	a_refresh_rate:
	assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		refresh_stb && ce_in |=> !refresh_cnt_ff ##0 !refresh_stb)
	else $error("refresh not every second word");

endmodule

// file: core/sdlc_pkg.sv
package sdlc_pkg;

	// clocking
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          INT_OSC_HZ     = 4_915_200;
	localparam int          EXT_CLK_MAX_HZ = 5_050_000;
	localparam int          PHASE_W        = 17;
	localparam logic [17:0] PHASE_STEP     = 18'h0c000;
	localparam logic [17:0] PHASE_MOD      = 18'h186a0;
	localparam logic        SEL_RST        = 1'b0;

	// filter and conversion timing
	localparam int OSR_DEF        = 61440;
	localparam int MOD_DIV_DEF    = 16;
	localparam int SINC_ORDER     = 4;
	localparam int OUT_W          = 24;
	localparam int FIRST_NOTCH_HZ = 5;
	localparam int NOTCH_50_IDX   = 10;
	localparam int NOTCH_60_IDX   = 12;
	localparam int CUTOFF_X1000   = 228;
	localparam int OVERRANGE_PCT  = 25;
	localparam int OUT_PERIOD_MS  = 200;
	localparam int HOST_WAIT_MS   = 800;
	localparam int SETTLE_WORDS   = HOST_WAIT_MS / OUT_PERIOD_MS;
	localparam logic [2:0] SETTLE_CNT = 3'(SETTLE_WORDS);

	// display
	localparam int         BP_N          = 3;
	localparam int         SEG_MAX       = 13;
	localparam int         SEG_35        = 10;
	localparam int         FRAME_W       = BP_N * SEG_MAX;
	localparam int         REFRESH_WORDS = 2;
	localparam int         MUX_DIV_DEF   = 256;
	localparam logic [1:0] PHASE_LAST    = 2'h2;

	// count weight in microvolts, 2 V range; fine range is ten times finer
	localparam logic [15:0] CW_UV_45   = 16'h0064;
	localparam logic [15:0] CW_UV_35   = 16'h03e8;
	localparam int          RANGE_FINE = 10;

	typedef logic [BP_N-1:0][SEG_MAX-1:0] sdlc_frame_type;

	typedef struct packed {
		logic [OUT_W-1:0] word;
		logic             settled;
	} sdlc_result_type;

endpackage

// file: core/sdlc_sinc_stage.sv
`timescale 1ns/1ps
module sdlc_sinc_stage import sdlc_pkg::*; #(
	parameter int W = 8
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	input  wire logic         integ_en_in,
	input  wire logic         comb_en_in,
	input  wire logic [W-1:0] integ_in,
	output logic      [W-1:0] integ_out,
	input  wire logic [W-1:0] comb_in,
	output logic      [W-1:0] comb_out
);

	logic [W-1:0] integ_ff;
	logic [W-1:0] dly_ff;
	logic [W-1:0] comb_ff;
	logic [W-1:0] nxt_integ;
	logic [W-1:0] nxt_dly;
	logic [W-1:0] nxt_comb;

	// modular wrap is intended: the comb differences cancel it exactly
	always_comb begin
		nxt_integ = integ_ff;
		nxt_dly   = dly_ff;
		nxt_comb  = comb_ff;
		if (integ_en_in) begin
			nxt_integ = W'(integ_ff + integ_in);
		end
		if (comb_en_in) begin
			nxt_dly  = comb_in;
			nxt_comb = W'(comb_in - dly_ff);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			integ_ff <= '0;
			dly_ff   <= '0;
			comb_ff  <= '0;
		end else if (ce_in) begin
			integ_ff <= nxt_integ;
			dly_ff   <= nxt_dly;
			comb_ff  <= nxt_comb;
		end
	end

	assign integ_out = integ_ff;
	assign comb_out  = comb_ff;

endmodule

// file: sim/sdlc_host_model.sv
`timescale 1ns/1ps
module sdlc_host_model (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        ext_run_in,
	input  wire logic        eoc_n_in,
	input  wire logic [31:0] half_ns_in,
	output logic             ext_clk_out,
	output logic             result_read_out
);
	int wait_q;

	// pin parked low while idle; odd start offset keeps edges off clk edges when the half period is even
	always begin
		if (!ext_run_in) begin
			ext_clk_out = 1'b0;
			@(posedge ext_run_in);
			#37;
		end else begin
			#((half_ns_in < 32'd99) ? 32'd99 : half_ns_in);
			ext_clk_out = ~ext_clk_out;
		end
	end

	// slow reader: result is fetched seven cycles after eoc falls
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_q          <= 0;
			result_read_out <= 1'b0;
		end else begin
			result_read_out <= (wait_q == 6);
			wait_q          <= (eoc_n_in || wait_q == 6) ? 0 : wait_q + 1;
		end
	end
endmodule

// file: sim/sdlc_core_tb_top.sv
`timescale 1ns/1ps
module sdlc_core_tb_top import sdlc_pkg::*;;
	logic            clk_sys_in = 1'b0;
	logic            rst_n_in = 1'b0;
	logic            ce_in = 1'b1;
	logic            mod_bit_in = 1'b0;
	logic            clock_source_select_in = 1'b0;
	logic            display_host_mode_in = 1'b0;
	sdlc_frame_type  host_frame_in = '0;
	logic            range_fine_in = 1'b0;
	logic            ext_run = 1'b0;
	logic [31:0]     ext_half_ns = 32'd203;
	logic            ext_clk_in;
	logic            result_read_in;
	logic            mod_clk_en_out;
	logic            eoc_n_out;
	logic            clock_source_active_out;
	logic            backplane_drive_one_out;
	logic            backplane_drive_two_out;
	logic            backplane_drive_three_out;
	sdlc_result_type result_out;
	sdlc_result_type last_res;
	logic [15:0]     count_weight_uv_out;
	logic [12:0]     segment_lines_out;
	logic [1:0]      bit_mode = 2'h0;
	logic            eoc_q = 1'b1;
	int              seed = 32'h45d06dcc;
	int              words = 0;
	int              cyc = 0;
	int              failures = 0;
	int              comparisons = 0;
	int              ticks = 0;
	localparam int   T_OSR = 8;
	localparam int   T_MOD = 2;

	sdlc_core #(.OSR(T_OSR), .MOD_DIV(T_MOD), .MUX_DIV(4)) uut (.clk_sys_in, .rst_n_in, .ce_in, .mod_bit_in, .ext_clk_in,
		.clock_source_select_in, .display_host_mode_in, .host_frame_in, .range_fine_in, .result_read_in,
		.mod_clk_en_out, .result_out, .eoc_n_out, .clock_source_active_out, .count_weight_uv_out,
		.backplane_drive_one_out, .backplane_drive_two_out, .backplane_drive_three_out, .segment_lines_out);

	sdlc_host_model host (.clk_sys_in, .rst_n_in, .ext_run_in(ext_run), .eoc_n_in(eoc_n_out),
		.half_ns_in(ext_half_ns), .ext_clk_out(ext_clk_in), .result_read_out(result_read_in));

	always #50 clk_sys_in = ~clk_sys_in;

	always @(posedge clk_sys_in) begin
		cyc        <= cyc + 1;
		ticks      <= ticks + int'(mod_clk_en_out);
		mod_bit_in <= (bit_mode == 2'h2) ? 1'($random(seed)) : bit_mode[0];
		if (eoc_q === 1'b1 && eoc_n_out === 1'b0) begin
			words    <= words + 1;
			last_res <= result_out;
		end
		eoc_q <= eoc_n_out;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	// source edges per word times clk cycles per internal oscillator edge
	function automatic int exp_cycles(input int n);
		return n * T_OSR * T_MOD * (CLK_HZ / 1000) / (INT_OSC_HZ / 1000);
	endfunction

	// an all-ones stream sums to OSR^4, top-aligned into the result word
	function automatic logic [OUT_W-1:0] exp_full_scale();
		int     acc;
		longint v;
		acc = SINC_ORDER * $clog2(T_OSR) + 1;
		v   = 1;
		for (int i = 0; i < SINC_ORDER; i++) v = v * T_OSR;
		if (acc < OUT_W) return OUT_W'(v << (OUT_W - acc));
		return OUT_W'(v >> (acc - OUT_W));
	endfunction

	task automatic wait_words(input int n);
		int target;
		int k;
		target = words + n;
		k = 0;
		while (words < target) begin
			@(negedge clk_sys_in);
			k++;
			if (k > 200 * n) begin
				check_val(0, 1, "result word timeout");
				tally_and_finish();
			end
		end
	endtask

	task automatic wait_active(input logic v);
		int k;
		for (k = 0; k < 200 && clock_source_active_out !== v; k++) @(negedge clk_sys_in);
		check_val(clock_source_active_out, v, "source in use");
		if (k == 200) tally_and_finish();
	endtask

	// phase is read off the odd backplane; segments must match that row
	task automatic check_disp(input sdlc_frame_type f, input int n);
		logic [2:0] bp;
		int         p;
		for (int c = 0; c < n; c++) begin
			@(negedge clk_sys_in);
			bp = {backplane_drive_three_out, backplane_drive_two_out, backplane_drive_one_out};
			p = 3;
			for (int i = 0; i < 3; i++) if (bp[i] != bp[(i+1)%3] && bp[i] != bp[(i+2)%3]) p = i;
			if (p == 3) check_val(bp, 3'h1, "backplane phase");
			else check_val(segment_lines_out, 13'({13{bp[(p+1)%3]}} ^ ~f[p]), "segments");
		end
	endtask

	initial begin
		int              t0;
		int              t_int;
		int              t_ext;
		int              tk;
		int              k;
		sdlc_result_type w1;
		sdlc_frame_type  fr [3];
		repeat (8) @(negedge clk_sys_in);
		check_val(eoc_n_out, 1, "eoc in reset");
		check_val(clock_source_active_out, 0, "source in reset");
		check_val({backplane_drive_three_out, backplane_drive_two_out, backplane_drive_one_out}, 3'h1, "bp");
		check_val(segment_lines_out, 13'h1fff, "segments in reset");
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check_val(count_weight_uv_out, CW_UV_45, "weight coarse");
		@(posedge clk_sys_in);
		range_fine_in <= 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check_val(count_weight_uv_out, CW_UV_45 / RANGE_FINE, "weight fine");
		$display("test reset_and_weight done");

		for (int i = 1; i <= 5; i++) begin
			wait_words(1);
			check_val(last_res.settled, i >= 4, "settled flag");
			check_val(last_res.word, 0, "zero input word");
		end
		repeat (3) @(negedge clk_sys_in);
		check_val(eoc_n_out, 0, "eoc held until read");
		for (k = 0; k < 20 && eoc_n_out !== 1'b1; k++) @(negedge clk_sys_in);
		check_val(eoc_n_out, 1, "eoc released by read");
		check_disp('0, 40);
		wait_words(1);
		t0 = cyc;
		tk = ticks;
		wait_words(4);
		t_int = cyc - t0;
		check_val(t_int >= exp_cycles(4) - 2 && t_int <= exp_cycles(4) + 2, 1, "word rate");
		check_val(ticks - tk >= 4 * T_OSR - 1 && ticks - tk <= 4 * T_OSR + 1, 1, "ticks per word");
		$display("test zero_input_auto_display done");

		@(posedge clk_sys_in);
		bit_mode <= 2'h1;
		wait_words(6);
		w1 = last_res;
		check_val(w1.word, exp_full_scale(), "full scale word");
		wait_words(1);
		check_val(last_res.word, w1.word, "steady full scale");
		@(posedge clk_sys_in);
		bit_mode <= 2'h2;
		wait_words(5);
		check_val(last_res.word <= w1.word, 1, "no wrap above full scale");
		$display("test full_scale_and_random done");

		fr[0] = '1;
		fr[1] = '0;
		fr[2] = FRAME_W'({$random(seed), $random(seed)});
		@(posedge clk_sys_in);
		display_host_mode_in <= 1'b1;
		host_frame_in        <= fr[0];
		wait_words(3);
		for (int j = 1; j < 3; j++) begin
			check_disp(fr[j-1], 10);
			@(posedge clk_sys_in);
			host_frame_in <= fr[j];
			check_disp(fr[j-1], 10);
			wait_words(3);
		end
		check_disp(fr[2], 10);
		$display("test host_display done");

		@(posedge clk_sys_in);
		ext_run                <= 1'b1;
		clock_source_select_in <= 1'b1;
		wait_active(1'b1);
		wait_words(1);
		check_val(last_res.settled, 0, "settle restart");
		t0 = cyc;
		wait_words(4);
		t_ext = cyc - t0;
		check_val(t_ext * 10 >= t_int * 19 && t_ext * 10 <= t_int * 21, 1, "half clock halves rate");
		@(posedge clk_sys_in);
		clock_source_select_in <= 1'b0;
		wait_active(1'b0);
		@(posedge clk_sys_in);
		ext_run <= 1'b0;
		$display("test clock_switch done");
		tally_and_finish();
	end
endmodule
